// ---- shared/prog_seq_pkg.sv ----
package prog_seq_pkg;

    localparam int PcWidth = 13;
    localparam int PageLsb = 11;
    localparam int OperandWidth = 11;
    localparam int SlotWidth = 16;
    localparam int SlotCount = 9;
    localparam int IndexWidth = 4;
    localparam int SlotBits = 13;

    localparam logic [PcWidth-1:0] PcResetValue = 13'h0000;
    localparam logic [PcWidth-1:0] PcStep = 13'h0001;
    localparam logic [PcWidth-1:0] ProgramLastAddr = 13'h1EFB;
    localparam logic [IndexWidth-1:0] IndexResetValue = 4'h9;
    localparam logic [IndexWidth-1:0] IndexStep = 4'h1;
    localparam logic [IndexWidth-1:0] IndexLastSlot = 4'h8;
    localparam logic [3:0] ReturnStackIndexAddr = 4'h1;
    localparam logic [1:0] PageZero = 2'h0;
    localparam logic [2:0] SlotPadZero = 3'h0;

    // Interrupt vectors, highest priority first.
    localparam logic [PcWidth-1:0] VecExtIrq0 = 13'h0006;
    localparam logic [PcWidth-1:0] VecExtIrq1 = 13'h0005;
    localparam logic [PcWidth-1:0] VecTimer12 = 13'h0004;
    localparam logic [PcWidth-1:0] VecBasicTimer = 13'h0003;
    localparam logic [PcWidth-1:0] VecSerial0 = 13'h0002;
    localparam logic [PcWidth-1:0] VecFreqCount = 13'h0001;
    localparam int IrqSources = 6;

    typedef enum logic [3:0] {
        OpNext = 4'h0,
        OpJumpDirect = 4'h1,
        OpJumpIndirect = 4'h2,
        OpCallDirect = 4'h3,
        OpCallIndirect = 4'h4,
        OpTableFetch = 4'h5,
        OpSubExit = 4'h6,
        OpExitSkip = 4'h7,
        OpIrqExit = 4'h8,
        OpPush = 4'h9,
        OpPop = 4'hA,
        OpIrqEntry = 4'hB,
        OpHold = 4'hC
    } seq_op_e;

    typedef enum logic [0:0] {
        TfIdle = 1'b0,
        TfRestore = 1'b1
    } table_state_e;

endpackage : prog_seq_pkg

// ---- design/return_stack_mem.sv ----
`timescale 1ns/1ps
module return_stack_mem
    import prog_seq_pkg::*;
(
    // Clock
    input wire logic clk,
    // Write side
    input wire logic wrEn,
    input wire logic [prog_seq_pkg::IndexWidth-1:0] wrIndex,
    input wire logic [prog_seq_pkg::SlotBits-1:0] wrData,
    // Read side
    input wire logic [prog_seq_pkg::IndexWidth-1:0] rdIndex,
    output logic [prog_seq_pkg::SlotWidth-1:0] rdData
);
    import prog_seq_pkg::*;

    // Only the nine real slots get storage; higher indexes have none.
    logic [SlotBits-1:0] slots [SlotCount];

    always_ff @(posedge clk)
    begin
        if (wrEn && (wrIndex <= IndexLastSlot))
        begin
            slots[wrIndex] <= wrData;
        end
    end

    // Unbacked slots read zero here; software must treat them as undefined.
    always_comb
    begin
        if (rdIndex <= IndexLastSlot)
        begin
            rdData = {SlotPadZero, slots[rdIndex]};
        end
        else
        begin
            rdData = {SlotPadZero, PcResetValue};
        end
    end

endmodule : return_stack_mem

// ---- design/program_sequencer_return_stack.sv ----
`timescale 1ns/1ps
// How it works
// - A 13-bit program counter addresses program memory; its top two bits select page.
// - Direct jump loads operand plus page bits, reaching 0000H to 1FFFH.
// - Indirect jump loads the counter from the address register.
// - Direct call forces page bits zero, so targets lie in 0000H to 07FFH.
// - Indirect call loads the counter from the address register.
// - Table fetch reads any program address, pointed to by the address register.
// - A call or accepted interrupt saves a return address on the stack.
// - Table fetch pushes the return address, then restores the counter from the stack.
// - Interrupt entry loads a fixed vector per source, chosen in priority order.
// - Power-on and chip-enable reset clear the counter to 0000H.
// - Addresses 1EFCH to 1FFFH hold undefined contents; software avoids them.
// - Sixteen stack slots exist by index, but only slots 0 to 8 store.
// - The upper three bits of every stored slot read as zero.
// - A 4-bit stack index selects the slot of the same number.
// - Register instructions read and write the stack index at address 01H.
// - All three resets set the stack index to 1001 binary.
// - Call or interrupt decrements the index, then writes the return address.
// - Return loads the counter from the selected slot, then increments the index.
// - Push decrements then stores address register; pop reads then increments.
// - Index values 09H to 0FH select unbacked slots that read undefined; here they read as zero.
module program_sequencer_return_stack
    import prog_seq_pkg::*;
(
    // Clock and resets
    input wire logic clk,
    input wire logic srst,
    input wire logic clockStopRst,
    input wire logic chipEnableRst,
    // Decoded instruction
    input wire logic opValid,
    input wire logic [3:0] opCode,
    input wire logic [prog_seq_pkg::OperandWidth-1:0] operand,
    input wire logic [1:0] pageSel,
    input wire logic [prog_seq_pkg::SlotBits-1:0] addressReg,
    // Interrupt acceptance, one bit per source, bit 0 highest priority
    input wire logic [prog_seq_pkg::IrqSources-1:0] irqAccept,
    // Register instruction port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [3:0] regAddr,
    input wire logic [3:0] regWrData,
    output logic [3:0] regRdData,
    // Program memory side
    output logic [prog_seq_pkg::PcWidth-1:0] instrPointer,
    output logic tableFetchStrobe,
    output logic [prog_seq_pkg::PcWidth-1:0] tableFetchAddr,
    output logic popValid,
    output logic [prog_seq_pkg::SlotBits-1:0] popData,
    output logic outOfRange
);
    import prog_seq_pkg::*;

    typedef struct packed {
        logic [PcWidth-1:0] pc;
        logic [IndexWidth-1:0] idx;
        table_state_e tf;
        logic tfStrobe;
        logic [PcWidth-1:0] tfAddr;
        logic popV;
        logic [SlotBits-1:0] popD;
        logic [3:0] rd;
        logic oor;
    } seq_state_s;

    seq_state_s state_q;
    seq_state_s state_d;
    logic stkWrEn;
    logic [IndexWidth-1:0] stkWrIndex;
    logic [SlotBits-1:0] stkWrData;
    logic [SlotWidth-1:0] stkRdData;
    logic [IndexWidth-1:0] idxDec;
    logic [PcWidth-1:0] pcInc;
    logic [PcWidth-1:0] irqVector;
    seq_op_e op;

    assign op = seq_op_e'(opCode);
    assign idxDec = state_q.idx - IndexStep;
    assign pcInc = state_q.pc + PcStep;

    // Reads of the stack use the current index; writes use the decremented one.
    return_stack_mem stack
    (
        .clk(clk),
        .wrEn(stkWrEn),
        .wrIndex(stkWrIndex),
        .wrData(stkWrData),
        .rdIndex(state_q.idx),
        .rdData(stkRdData)
    );

    always_comb
    begin
        irqVector = VecFreqCount;
        if (irqAccept[0])
        begin
            irqVector = VecExtIrq0;
        end
        else if (irqAccept[1])
        begin
            irqVector = VecExtIrq1;
        end
        else if (irqAccept[2])
        begin
            irqVector = VecTimer12;
        end
        else if (irqAccept[3])
        begin
            irqVector = VecBasicTimer;
        end
        else if (irqAccept[4])
        begin
            irqVector = VecSerial0;
        end
    end

    always_comb
    begin
        state_d = state_q;
        state_d.tfStrobe = 1'b0;
        state_d.popV = 1'b0;
        stkWrEn = 1'b0;
        stkWrIndex = idxDec;
        stkWrData = pcInc;
        if (state_q.tf == TfRestore)
        begin
            // Second half of a table fetch: return to the saved address.
            state_d.pc = stkRdData[PcWidth-1:0];
            state_d.idx = state_q.idx + IndexStep;
            state_d.tf = TfIdle;
        end
        else if (|irqAccept)
        begin
            // Interrupt entry saves the address of the instruction not yet run.
            stkWrEn = 1'b1;
            stkWrData = state_q.pc;
            state_d.idx = idxDec;
            state_d.pc = irqVector;
        end
        else if (opValid)
        begin
            unique case (op)
                OpJumpDirect:
                    state_d.pc = {pageSel, operand};
                OpJumpIndirect:
                    state_d.pc = addressReg;
                OpCallDirect:
                begin
                    stkWrEn = 1'b1;
                    state_d.idx = idxDec;
                    state_d.pc = {PageZero, operand};
                end
                OpCallIndirect:
                begin
                    stkWrEn = 1'b1;
                    state_d.idx = idxDec;
                    state_d.pc = addressReg;
                end
                OpTableFetch:
                begin
                    stkWrEn = 1'b1;
                    state_d.idx = idxDec;
                    state_d.tfStrobe = 1'b1;
                    state_d.tfAddr = addressReg;
                    state_d.tf = TfRestore;
                end
                OpSubExit, OpExitSkip, OpIrqExit:
                begin
                    state_d.pc = stkRdData[PcWidth-1:0];
                    state_d.idx = state_q.idx + IndexStep;
                end
                OpPush:
                begin
                    stkWrEn = 1'b1;
                    stkWrData = addressReg;
                    state_d.idx = idxDec;
                    state_d.pc = pcInc;
                end
                OpPop:
                begin
                    state_d.popV = 1'b1;
                    state_d.popD = stkRdData[SlotBits-1:0];
                    state_d.idx = state_q.idx + IndexStep;
                    state_d.pc = pcInc;
                end
                OpHold:
                    state_d.pc = state_q.pc;
                OpNext:
                    state_d.pc = pcInc;
                default:
                    state_d.pc = pcInc;
            endcase
        end
        if (regWrite && (regAddr == ReturnStackIndexAddr) && (state_q.tf == TfIdle)
            && !(|irqAccept))
        begin
            state_d.idx = regWrData;
        end
        if (regRead && (regAddr == ReturnStackIndexAddr))
        begin
            state_d.rd = state_q.idx;
        end
        else if (regRead)
        begin
            state_d.rd = 4'h0;
        end
        // Flags a counter that strays beyond the end of program memory.
        state_d.oor = (state_d.pc > ProgramLastAddr);
    end

    always_ff @(posedge clk)
    begin
        if (srst || chipEnableRst)
        begin
            state_q <= '0;
            state_q.pc <= PcResetValue;
            state_q.idx <= IndexResetValue;
            state_q.tf <= TfIdle;
        end
        else if (clockStopRst)
        begin
            // Clock-stop reset leaves the counter alone but resets the index.
            state_q <= state_d;
            state_q.idx <= IndexResetValue;
            state_q.tf <= TfIdle;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign instrPointer = state_q.pc;
    assign tableFetchStrobe = state_q.tfStrobe;
    assign tableFetchAddr = state_q.tfAddr;
    assign popValid = state_q.popV;
    assign popData = state_q.popD;
    assign regRdData = state_q.rd;
    assign outOfRange = state_q.oor;

    reset_clears_pc_a: assert property (@(posedge clk)
        (srst || chipEnableRst) |=> (instrPointer == PcResetValue))
        else $error("Counter not cleared by reset.");

    reset_index_a: assert property (@(posedge clk)
        (srst || chipEnableRst || clockStopRst) |=> (state_q.idx == IndexResetValue))
        else $error("Stack index not set to nine by reset.");

    call_page_zero_a: assert property (@(posedge clk) disable iff (srst)
        (opValid && op == OpCallDirect && state_q.tf == TfIdle && !(|irqAccept)
            && !chipEnableRst)
        |=> (instrPointer[PcWidth-1:PageLsb] == PageZero))
        else $error("Direct call left page bits set.");

    call_push_a: assert property (@(posedge clk) disable iff (srst)
        (opValid && op == OpCallIndirect && state_q.tf == TfIdle && !(|irqAccept)
            && !regWrite && !chipEnableRst && !clockStopRst)
        |=> (state_q.idx == $past(idxDec)))
        else $error("Call did not decrement the stack index.");

    irq_vector_a: assert property (@(posedge clk) disable iff (srst)
        (irqAccept[0] && state_q.tf == TfIdle && !chipEnableRst)
        |=> (instrPointer == VecExtIrq0))
        else $error("External pin interrupt vector wrong.");

    return_restore_a: assert property (@(posedge clk) disable iff (srst)
        (opValid && op == OpSubExit && state_q.tf == TfIdle && !(|irqAccept)
            && !chipEnableRst)
        |=> (instrPointer == $past(stkRdData[PcWidth-1:0])))
        else $error("Return did not restore the counter.");

    table_round_a: assert property (@(posedge clk) disable iff (srst)
        (opValid && op == OpTableFetch && state_q.tf == TfIdle && !(|irqAccept)
            && !regWrite && !chipEnableRst && !clockStopRst)
        |=> tableFetchStrobe ##1 (instrPointer == $past(state_q.pc, 2) + PcStep))
        else $error("Table fetch did not return past itself.");

    step_next_a: assert property (@(posedge clk) disable iff (srst)
        (opValid && op == OpNext && state_q.tf == TfIdle && !(|irqAccept)
            && !chipEnableRst)
        |=> (instrPointer == $past(pcInc)))
        else $error("Counter did not advance by one.");

    irq_priority_a: assert property (@(posedge clk) disable iff (srst)
        (irqAccept[2] && !irqAccept[1] && !irqAccept[0] && state_q.tf == TfIdle
            && !chipEnableRst)
        |=> (instrPointer == VecTimer12))
        else $error("Timer interrupt vector or priority wrong.");

    irq_push_a: assert property (@(posedge clk) disable iff (srst)
        ((|irqAccept) && state_q.tf == TfIdle && !chipEnableRst && !clockStopRst)
        |=> (state_q.idx == $past(idxDec)))
        else $error("Interrupt entry did not decrement the stack index.");

    index_write_a: assert property (@(posedge clk) disable iff (srst)
        (regWrite && regAddr == ReturnStackIndexAddr && state_q.tf == TfIdle
            && !(|irqAccept) && !chipEnableRst && !clockStopRst)
        |=> (state_q.idx == $past(regWrData)))
        else $error("Register write did not load the stack index.");

    range_flag_a: assert property (@(posedge clk) disable iff (srst)
        outOfRange == (instrPointer > ProgramLastAddr))
        else $error("Range flag disagrees with the counter.");

endmodule : program_sequencer_return_stack

// ---- test/decoder_model.sv ----
`timescale 1ns/1ps
module decoder_model
    import prog_seq_pkg::*;
(
    // Clock
    input wire logic clk,
    // Decoded instruction
    output logic opValid,
    output logic [3:0] opCode,
    output logic [prog_seq_pkg::OperandWidth-1:0] operand,
    output logic [1:0] pageSel,
    output logic [prog_seq_pkg::SlotBits-1:0] addressReg,
    // Interrupt acceptance
    output logic [prog_seq_pkg::IrqSources-1:0] irqAccept
);
    initial
    begin
        opValid = 1'b0;
        opCode = 4'h0;
        operand = 11'h0;
        pageSel = 2'h0;
        addressReg = 13'h0;
        irqAccept = 6'h0;
    end

    // Called on a rising edge; returns at the edge that samples the request.
    task automatic issue(input logic [3:0] op, input logic [10:0] opnd = 11'h0,
        input logic [1:0] page = 2'h0, input logic [12:0] ar = 13'h0,
        input logic [5:0] irq = 6'h0);
        opValid <= (irq == 6'h0);
        opCode <= op;
        operand <= opnd;
        pageSel <= page;
        addressReg <= ar;
        irqAccept <= irq;
        @(posedge clk);
    endtask : issue

    // Idle fields flip so that a stale operand is never mistaken for a fresh one.
    task automatic rest();
        opValid <= 1'b0;
        irqAccept <= 6'h0;
        operand <= ~operand;
        pageSel <= ~pageSel;
    endtask : rest
endmodule : decoder_model

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
    import prog_seq_pkg::*;
    logic clk, srst, clockStopRst, chipEnableRst, opValid, regWrite, regRead;
    logic tableFetchStrobe, popValid, outOfRange;
    logic [3:0] opCode, regAddr, regWrData, regRdData;
    logic [10:0] operand;
    logic [1:0] pageSel;
    logic [12:0] addressReg, instrPointer, tableFetchAddr, popData;
    logic [5:0] irqAccept;
    logic [12:0] vecTab [6] = '{13'h0006, 13'h0005, 13'h0004, 13'h0003, 13'h0002, 13'h0001};
    int failures = 0;
    int cmpCount = 0;

    decoder_model dec (.clk(clk), .opValid(opValid), .opCode(opCode), .operand(operand),
        .pageSel(pageSel), .addressReg(addressReg), .irqAccept(irqAccept));
    program_sequencer_return_stack dut (.clk(clk), .srst(srst), .clockStopRst(clockStopRst),
        .chipEnableRst(chipEnableRst), .opValid(opValid), .opCode(opCode), .operand(operand),
        .pageSel(pageSel), .addressReg(addressReg), .irqAccept(irqAccept), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .instrPointer(instrPointer), .tableFetchStrobe(tableFetchStrobe),
        .tableFetchAddr(tableFetchAddr), .popValid(popValid), .popData(popData),
        .outOfRange(outOfRange));

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Results are read at the falling edge, well clear of the register update.
    task automatic look();
        dec.rest();
        @(negedge clk);
    endtask : look

    task automatic pcIs(input logic [12:0] exp);
        look();
        chk(instrPointer, exp);
        @(posedge clk);
    endtask : pcIs

    task automatic popIs(input logic [12:0] exp);
        look();
        chk(popValid, 1'b1);
        chk(popData, exp);
        @(posedge clk);
    endtask : popIs

    task automatic regWr(input logic [3:0] d);
        regWrite <= 1'b1;
        regAddr <= 4'h1;
        regWrData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : regWr

    task automatic regRd(input logic [3:0] a, input logic [3:0] exp);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        chk(regRdData, exp);
        @(posedge clk);
    endtask : regRd

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // The sequence needs about a hundred cycles; a hang is cut off well beyond that.
    initial
    begin
        #40000;
        failures++;
        end_of_test();
    end

    initial
    begin
        srst = 1'b1;
        clockStopRst = 1'b0;
        chipEnableRst = 1'b0;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 4'h0;
        regWrData = 4'h0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        pcIs(13'h0000);
        regRd(4'h1, 4'h9);
        dec.issue(OpNext);
        dec.issue(4'hF);
        pcIs(13'h0002);
        for (int p = 0; p < 4; p++)
        begin
            dec.issue(OpJumpDirect, 11'h6FB, 2'(p));
            pcIs({2'(p), 11'h6FB});
        end
        dec.issue(OpJumpIndirect, 11'h0, 2'h0, 13'h1EFC);
        look();
        chk(instrPointer, 13'h1EFC);
        chk(outOfRange, 1'b1);
        @(posedge clk);
        dec.issue(OpJumpDirect, 11'h123);
        look();
        chk(outOfRange, 1'b0);
        @(posedge clk);
        dec.issue(OpCallDirect, 11'h7FF, 2'h3);
        pcIs(13'h07FF);
        dec.issue(OpCallIndirect, 11'h0, 2'h0, 13'h1EFB);
        pcIs(13'h1EFB);
        regRd(4'h1, 4'h7);
        dec.issue(OpPush, 11'h0, 2'h0, 13'h0ABC);
        dec.issue(OpPop);
        popIs(13'h0ABC);
        regRd(4'h1, 4'h7);
        dec.issue(OpSubExit);
        pcIs(13'h0800);
        dec.issue(OpExitSkip);
        pcIs(13'h0124);
        regRd(4'h1, 4'h9);
        for (int i = 0; i < 6; i++)
        begin
            dec.issue(OpNext, 11'h0, 2'h0, 13'h0, 6'h01 << i);
            pcIs(vecTab[i]);
            regRd(4'h1, 4'h8);
            dec.issue(OpIrqExit);
            pcIs(13'h0124);
        end
        // Two sources at once: the higher one wins and an index write is refused.
        fork
            dec.issue(OpNext, 11'h0, 2'h0, 13'h0, 6'h0C);
            regWr(4'h2);
        join
        pcIs(13'h0004);
        regRd(4'h1, 4'h8);
        dec.issue(OpIrqExit);
        pcIs(13'h0124);
        // A jump or index write offered in the restore cycle must be ignored.
        dec.issue(OpTableFetch, 11'h0, 2'h0, 13'h1EFB);
        fork
            dec.issue(OpJumpDirect, 11'h555, 2'h1);
            regWr(4'h5);
            begin
                @(negedge clk);
                chk(tableFetchStrobe, 1'b1);
                chk(tableFetchAddr, 13'h1EFB);
            end
        join
        look();
        chk(instrPointer, 13'h0125);
        chk(tableFetchStrobe, 1'b0);
        @(posedge clk);
        regRd(4'h1, 4'h9);
        regWr(4'h3);
        dec.issue(OpPush, 11'h0, 2'h0, 13'h1555);
        dec.issue(OpPop);
        popIs(13'h1555);
        regRd(4'h2, 4'h0);
        regRd(4'h1, 4'h3);
        regWr(4'hF);
        dec.issue(OpPop);
        popIs(13'h0000);
        regRd(4'h1, 4'h0);
        clockStopRst <= 1'b1;
        @(posedge clk);
        clockStopRst <= 1'b0;
        dec.issue(OpNext);
        pcIs(13'h0129);
        dec.issue(OpHold);
        pcIs(13'h0129);
        regRd(4'h1, 4'h9);
        regWr(4'h4);
        chipEnableRst <= 1'b1;
        @(posedge clk);
        chipEnableRst <= 1'b0;
        pcIs(13'h0000);
        regRd(4'h1, 4'h9);
        end_of_test();
    end
endmodule : tb
